// ==== logic/usb_dev_cfg.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  usb device control register block.
  assumes: included by the package and the design file, no other dependency.
*/
`ifndef USB_DEV_CFG_SVH
`define USB_DEV_CFG_SVH

`define NUM_EP 7
`define CLK_MHZ 20
`define IDLE_TIME_US 3000
`define IDLE_CNT_W 17
`define FIFO_BYTES 832

`define OFS_FLAGS 8'h00
`define OFS_ENABLES 8'h04
`define OFS_ADDR 8'h08
`define OFS_FRAME_HI 8'h0c
`define OFS_FRAME_LO 8'h10
`define OFS_FRAME_ERR 8'h14
`define OFS_EP_SEL 8'h18
`define OFS_FIFO_RST 8'h1c
`define OFS_EP_CTRL 8'h20
`define OFS_EP_CFG0 8'h24
`define OFS_EP_CFG1 8'h28
`define OFS_EP_STA0 8'h2c

`define BIT_REMOTE_RESUME 6
`define BIT_RESUME_DONE 5
`define BIT_LINE_WAKE 4
`define BIT_BUS_RESET_DONE 3
`define BIT_FRAME_START 2
`define BIT_BUS_IDLE 0
`define FLAG_MASK 8'h7d
`define ENABLES_RESET 8'h08
`define BIT_ADDR_ACT 7
`define BIT_CRC_ERR 4
`define EP_SEL_FORBIDDEN 3'h7
`define BIT_STALL_RQ 5
`define BIT_STALL_CL 4
`define BIT_TOG_RST 3
`define BIT_EP_ON 0
`define POS_TYPE 6
`define BIT_DIR 0
`define POS_SIZE 4
`define POS_BANKS 2
`define BIT_CLAIM 1
`define BIT_CFG_OK 7
`define BIT_OVERRUN 6
`define BIT_STARVE 5
`define POS_TOGGLE 2
`define POS_BUSY 0
`define SIZE_MAX_EP1 3'h5
`define SIZE_MAX_OTHER 3'h3
`define WIDE_EP 3'h1

`endif

// ==== logic/usb_dev_ctrl.sv ====
/*
  control and status registers of a full/low-speed usb device controller,
  reached over apb: general event flags and enables, function address,
  frame number capture, endpoint selection and per-endpoint configuration.
  assumes: the usb protocol engine runs on pclk and reports its events as
  one-cycle pulses; only the bus idle level arrives from outside the domain.

  // Operation
  // - each start-of-frame token sets the frame start flag, nominally every 1 ms
  // - bus idle in J for 3 ms sets idle flag; software clears, writing one ignored
  // - flags are set by their events whatever their enable bits hold
  // - six enable bits match the flags; reset-done enable resets to one
  // - seven-bit address; writing activate bit enables it; hardware clears activate
  // - eleven-bit frame number of last start-of-frame read as high and low fields
  // - frame number is updated even from a corrupted start-of-frame
  // - crc error flag at bit 4 updates together with the frame start flag
  // - three-bit select picks the endpoint; value 111b is never written
  // - one fifo reset bit per endpoint, held by software then cleared
  // - stall request answers with STALL; a new SETUP clears it
  // - writing stall cancel drops the stall; the bit clears itself at once
  // - toggle reset forces DATA0 next; the bit clears itself at once
  // - bit 0 enables the endpoint; software enables endpoint 0 after reset
  // - type codes: 00b control, 01b iso, 10b bulk, 11b interrupt
  // - direction bit 0: set for IN, clear for OUT and control
  // - size codes 8..256 bytes, large ones endpoint 1 only; bank 00b/01b
  // - the claim bit reserves endpoint memory, clearing it releases it
  // - setting claim updates config valid at bit 7 from size and banks
  // - iso overrun bit 6 and starve bit 5 set by errors, software clears
  // - toggle status reads 00b for DATA0 and 01b for DATA1
  // - busy bank count reads 00b, 01b or 10b
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "usb_dev_cfg.svh"

module usb_dev_ctrl #(
  parameter int IDLE_CYCLES = `IDLE_TIME_US * `CLK_MHZ,
  parameter int FIFO_CAPACITY = `FIFO_BYTES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events from the protocol engine
  input wire logic sof_seen,
  input wire logic sof_crc_bad,
  input wire logic [10:0] sof_frame_number,
  input wire logic remote_resume_seen,
  input wire logic resume_done_seen,
  input wire logic line_wake_seen,
  input wire logic bus_reset_done_seen,
  input wire logic address_applied,
  // bus line state, asynchronous
  input wire logic line_idle_j,
  // per-endpoint events and status
  input wire logic [`NUM_EP-1:0] setup_seen,
  input wire logic [`NUM_EP-1:0] iso_overrun_seen,
  input wire logic [`NUM_EP-1:0] iso_starve_seen,
  input wire logic [`NUM_EP-1:0][1:0] toggle_state,
  input wire logic [`NUM_EP-1:0][1:0] busy_bank_count,
  // controls to the protocol engine
  output logic usb_irq,
  output logic [6:0] device_address,
  output logic address_activate,
  output logic [`NUM_EP-1:0] endpoint_fifo_reset_bits,
  output logic [`NUM_EP-1:0] stall_request,
  output logic [`NUM_EP-1:0] stall_cancel,
  output logic [`NUM_EP-1:0] toggle_reset,
  output logic [`NUM_EP-1:0] endpoint_on,
  output usb_dev_pkg::xfer_kind_type [`NUM_EP-1:0] transfer_type,
  output logic [`NUM_EP-1:0] transfer_direction,
  output logic [`NUM_EP-1:0][2:0] buffer_size_code,
  output logic [`NUM_EP-1:0][1:0] bank_count_code,
  output logic [`NUM_EP-1:0] memory_claim,
  output logic [`NUM_EP-1:0] config_valid,
  output logic [`NUM_EP-1:0] endpoint_irq_summary
);
  import usb_dev_pkg::*;

  ctrl_state_type s;
  ctrl_state_type next_s;

  always_comb begin
    logic wr;
    logic ep_ok;
    logic [2:0] e;
    logic [2:0] wsize;
    logic [1:0] wbanks;
    logic [31:0] rd;
    logic hit;
    wr = psel & penable & pwrite;
    e = s.ep_sel;
    ep_ok = (s.ep_sel != `EP_SEL_FORBIDDEN);
    wsize = pwdata[`POS_SIZE +: 3];
    wbanks = pwdata[`POS_BANKS +: 2];
    rd = 32'h0;
    hit = 1'b1;
    next_s = s;
    next_s.stall_cl = '0;
    next_s.tog_rst = '0;

    // bus idle filter: the first stage feeds only the second
    next_s.idle_sync = {s.idle_sync[1:0], line_idle_j};
    if (s.idle_sync[1] == s.idle_sync[2]) begin
      next_s.idle_level = s.idle_sync[2];
    end
    if (!s.idle_level) begin
      next_s.idle_count = '0;
    end else if (s.idle_count != `IDLE_CNT_W'(IDLE_CYCLES)) begin
      next_s.idle_count = s.idle_count + `IDLE_CNT_W'(1);
    end

    // software writes, taken at the access edge
    if (wr) begin
      case (paddr)
        `OFS_FLAGS: begin
          next_s.flags = s.flags & pwdata[7:0] & `FLAG_MASK;
        end
        `OFS_ENABLES: begin
          next_s.enables = pwdata[7:0] & `FLAG_MASK;
        end
        `OFS_ADDR: begin
          next_s.dev_addr = pwdata[6:0];
          if (pwdata[`BIT_ADDR_ACT]) begin
            next_s.addr_act = 1'b1;
          end
        end
        `OFS_EP_SEL: begin
          next_s.ep_sel = pwdata[2:0];
        end
        `OFS_FIFO_RST: begin
          next_s.fifo_rst = pwdata[`NUM_EP-1:0];
        end
        `OFS_EP_CTRL: begin
          if (ep_ok) begin
            if (pwdata[`BIT_STALL_RQ]) begin
              next_s.stall_rq[e] = 1'b1;
            end
            if (pwdata[`BIT_STALL_CL]) begin
              next_s.stall_cl[e] = 1'b1;
              next_s.stall_rq[e] = 1'b0;
            end
            next_s.tog_rst[e] = pwdata[`BIT_TOG_RST];
            next_s.ep_on[e] = pwdata[`BIT_EP_ON];
          end
        end
        `OFS_EP_CFG0: begin
          if (ep_ok) begin
            next_s.ttype[e] = xfer_kind_type'(pwdata[`POS_TYPE +: 2]);
            next_s.dir[e] = pwdata[`BIT_DIR];
          end
        end
        `OFS_EP_CFG1: begin
          if (ep_ok) begin
            next_s.size[e] = wsize;
            next_s.banks[e] = wbanks;
            next_s.claim[e] = pwdata[`BIT_CLAIM];
            if (pwdata[`BIT_CLAIM]) begin
              next_s.cfg_ok[e] = (wsize <= ((e == `WIDE_EP) ? `SIZE_MAX_EP1 : `SIZE_MAX_OTHER))
                & !wbanks[1]
                & (((32'd8 << wsize) * (32'd1 + 32'(wbanks[0]))) <= 32'(FIFO_CAPACITY));
            end
          end
        end
        `OFS_EP_STA0: begin
          if (ep_ok) begin
            next_s.overrun[e] = s.overrun[e] & pwdata[`BIT_OVERRUN];
            next_s.starve[e] = s.starve[e] & pwdata[`BIT_STARVE];
          end
        end
        default: begin
        end
      endcase
    end

    // hardware events come after the writes so they win over a software write in the same cycle
    if (address_applied) begin
      next_s.addr_act = 1'b0;
    end
    if (s.idle_level && s.idle_count == `IDLE_CNT_W'(IDLE_CYCLES - 1)) begin
      next_s.flags[`BIT_BUS_IDLE] = 1'b1;
    end
    if (remote_resume_seen) begin
      next_s.flags[`BIT_REMOTE_RESUME] = 1'b1;
    end
    if (resume_done_seen) begin
      next_s.flags[`BIT_RESUME_DONE] = 1'b1;
    end
    if (line_wake_seen) begin
      next_s.flags[`BIT_LINE_WAKE] = 1'b1;
    end
    if (bus_reset_done_seen) begin
      next_s.flags[`BIT_BUS_RESET_DONE] = 1'b1;
    end
    if (sof_seen) begin
      next_s.flags[`BIT_FRAME_START] = 1'b1;
      next_s.frame = sof_frame_number;
      next_s.crc_err = sof_crc_bad;
    end
    for (int i = 0; i < `NUM_EP; i++) begin
      if (setup_seen[i]) begin
        next_s.stall_rq[i] = 1'b0;
      end
      if (iso_overrun_seen[i] && s.ttype[i] == xfer_iso) begin
        next_s.overrun[i] = 1'b1;
      end
      if (iso_starve_seen[i] && s.ttype[i] == xfer_iso) begin
        next_s.starve[i] = 1'b1;
      end
    end

    // read data is captured in the setup phase and held for the access phase
    case (paddr)
      `OFS_FLAGS: rd = {24'h0, s.flags};
      `OFS_ENABLES: rd = {24'h0, s.enables};
      `OFS_ADDR: rd = {25'h0, s.dev_addr};
      `OFS_FRAME_HI: rd = {29'h0, s.frame[10:8]};
      `OFS_FRAME_LO: rd = {24'h0, s.frame[7:0]};
      `OFS_FRAME_ERR: rd = {27'h0, s.crc_err, 4'h0};
      `OFS_EP_SEL: rd = {29'h0, s.ep_sel};
      `OFS_FIFO_RST: rd = {25'h0, s.fifo_rst};
      `OFS_EP_CTRL: begin
        if (ep_ok) begin
          rd = {26'h0, s.stall_rq[e], s.stall_cl[e], s.tog_rst[e], 2'h0, s.ep_on[e]};
        end
      end
      `OFS_EP_CFG0: begin
        if (ep_ok) begin
          rd = {24'h0, s.ttype[e], 5'h0, s.dir[e]};
        end
      end
      `OFS_EP_CFG1: begin
        if (ep_ok) begin
          rd = {25'h0, s.size[e], s.banks[e], s.claim[e], 1'b0};
        end
      end
      `OFS_EP_STA0: begin
        if (ep_ok) begin
          rd = {24'h0, s.cfg_ok[e], s.overrun[e], s.starve[e], 1'b0,
                toggle_state[e], busy_bank_count[e]};
        end
      end
      default: hit = 1'b0;
    endcase
    if (psel && !penable) begin
      next_s.rdata = rd;
      next_s.slverr = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.enables <= `ENABLES_RESET;
    end else begin
      s <= next_s;
    end
  end

  // one wait-free access phase: data was latched during setup
  assign pready = psel & penable;
  assign prdata = s.rdata;
  assign pslverr = psel & penable & s.slverr;

  assign usb_irq = |(s.flags & s.enables);
  assign device_address = s.dev_addr;
  assign address_activate = s.addr_act;
  assign endpoint_fifo_reset_bits = s.fifo_rst;
  assign stall_request = s.stall_rq;
  assign stall_cancel = s.stall_cl;
  assign toggle_reset = s.tog_rst;
  assign endpoint_on = s.ep_on;
  assign transfer_type = s.ttype;
  assign transfer_direction = s.dir;
  assign buffer_size_code = s.size;
  assign bank_count_code = s.banks;
  assign memory_claim = s.claim;
  assign config_valid = s.cfg_ok;
  assign endpoint_irq_summary = s.overrun | s.starve;

endmodule

// ==== logic/usb_dev_pkg.sv ====
/*
  types of the usb device control register block.
  assumes: usb_dev_cfg.svh on the include path.
*/
`include "usb_dev_cfg.svh"

package usb_dev_pkg;

  typedef enum logic [1:0] {
    xfer_control = 2'h0,
    xfer_iso = 2'h1,
    xfer_bulk = 2'h2,
    xfer_interrupt = 2'h3
  } xfer_kind_type;

  typedef struct packed {
    logic [2:0] idle_sync;
    logic idle_level;
    logic [`IDLE_CNT_W-1:0] idle_count;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [6:0] dev_addr;
    logic addr_act;
    logic [10:0] frame;
    logic crc_err;
    logic [2:0] ep_sel;
    logic [`NUM_EP-1:0] fifo_rst;
    logic [`NUM_EP-1:0] stall_rq;
    logic [`NUM_EP-1:0] stall_cl;
    logic [`NUM_EP-1:0] tog_rst;
    logic [`NUM_EP-1:0] ep_on;
    logic [`NUM_EP-1:0] dir;
    logic [`NUM_EP-1:0] claim;
    logic [`NUM_EP-1:0] cfg_ok;
    logic [`NUM_EP-1:0] overrun;
    logic [`NUM_EP-1:0] starve;
    xfer_kind_type [`NUM_EP-1:0] ttype;
    logic [`NUM_EP-1:0][1:0] banks;
    logic [`NUM_EP-1:0][2:0] size;
    logic [31:0] rdata;
    logic slverr;
  } ctrl_state_type;

endpackage

// ==== testbench/tb_usb_device_ctrl_regs.sv ====
/* self-checking bench for usb_dev_ctrl with an apb master.
   assumes: usb_host_model and the checker compiled before. */
`timescale 1ns/100ps
`include "usb_dev_cfg.svh"
module tb_usb_device_ctrl_regs;
  import usb_dev_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, usb_irq, address_activate, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0] ev;
  logic [6:0] device_address, setup_seen, iso_overrun_seen, iso_starve_seen, endpoint_fifo_reset_bits;
  logic [6:0] stall_request, stall_cancel, toggle_reset, endpoint_on, transfer_direction;
  logic [6:0] memory_claim, config_valid, endpoint_irq_summary;
  logic [6:0][1:0] toggle_state, busy_bank_count, bank_count_code;
  logic [6:0][2:0] buffer_size_code;
  xfer_kind_type [6:0] transfer_type;
  wire logic sof_seen, sof_crc_bad, line_idle_j;
  wire logic [10:0] sof_frame_number;
  int err_total, checked, v, e;
  int fb[6] = '{0, 2, 3, 4, 5, 6};
  usb_dev_ctrl #(.IDLE_CYCLES(20)) usb_dev_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sof_seen(sof_seen), .sof_crc_bad(sof_crc_bad), .sof_frame_number(sof_frame_number),
    .remote_resume_seen(ev[4]), .resume_done_seen(ev[3]), .line_wake_seen(ev[2]), .bus_reset_done_seen(ev[1]),
    .address_applied(ev[0]), .line_idle_j(line_idle_j), .setup_seen(setup_seen),
    .iso_overrun_seen(iso_overrun_seen), .iso_starve_seen(iso_starve_seen), .toggle_state(toggle_state),
    .busy_bank_count(busy_bank_count), .usb_irq(usb_irq), .device_address(device_address),
    .address_activate(address_activate), .endpoint_fifo_reset_bits(endpoint_fifo_reset_bits),
    .stall_request(stall_request), .stall_cancel(stall_cancel), .toggle_reset(toggle_reset),
    .endpoint_on(endpoint_on), .transfer_type(transfer_type), .transfer_direction(transfer_direction),
    .buffer_size_code(buffer_size_code), .bank_count_code(bank_count_code), .memory_claim(memory_claim),
    .config_valid(config_valid), .endpoint_irq_summary(endpoint_irq_summary));
  usb_host_model usb_host_model_inst (.pclk(pclk), .sof_seen(sof_seen), .sof_crc_bad(sof_crc_bad),
    .sof_frame_number(sof_frame_number), .line_idle_j(line_idle_j));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    {psel, penable} <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(0, a, 0);
    chk(r, want);
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1;
    @(posedge pclk);
    ev <= 0;
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, setup_seen, iso_overrun_seen, iso_starve_seen} = 0;
    {toggle_state, busy_bank_count} = 0;
    presetn = 0;
    v = $urandom(32'h6719);
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 12; i++) rd(8'(i * 4), i == 1 ? 8'h08 : 0);
    $display("test reset done");
    apb(1, 8'h04, 0); // reset-done enable cleared so no enable is set outside the enable sweep
    for (int b = 1; b < 5; b++) pulse(b);
    usb_host_model_inst.sof(11'h2a5, 0);
    usb_host_model_inst.idle(30);
    @(negedge pclk);
    chk(usb_irq, 0);
    apb(1, 8'h00, 8'hff);
    rd(8'h00, 8'h7d);
    foreach (fb[i]) begin
      apb(1, 8'h04, 1 << fb[i]);
      @(negedge pclk);
      chk(usb_irq, 1);
    end
    apb(1, 8'h04, 8'hff);
    rd(8'h04, 8'h7d);
    apb(1, 8'h00, 0);
    rd(8'h00, 0);
    chk(usb_irq, 0);
    $display("test flags done");
    repeat (4) begin
      v = $urandom % 2048;
      e = $urandom % 2;
      usb_host_model_inst.sof(11'(v), 1'(e));
      rd(8'h0c, v >> 8);
      rd(8'h10, v & 255);
      rd(8'h14, e << 4);
    end
    apb(1, 8'h08, 8'hc5);
    @(negedge pclk);
    chk({address_activate, device_address}, 8'hc5);
    apb(1, 8'h08, 8'h45);
    rd(8'h08, 8'h45);
    chk(address_activate, 1);
    pulse(0);
    @(negedge pclk);
    chk(address_activate, 0);
    $display("test frame and address done");
    apb(1, 8'h20, 1);
    @(negedge pclk);
    chk(endpoint_on[0], 1);
    apb(1, 8'h1c, 8'hff);
    rd(8'h1c, 8'h7f);
    chk(endpoint_fifo_reset_bits, 8'h7f);
    apb(1, 8'h1c, 0);
    apb(1, 8'h18, 1);
    rd(8'h18, 1);
    for (int t = 0; t < 4; t++) begin
      apb(1, 8'h24, t << 6 | (t != 0));
      rd(8'h24, t << 6 | (t != 0));
      chk({transfer_type[1], transfer_direction[1]}, t << 1 | (t != 0));
    end
    for (int s = 0; s < 8; s++) begin
      v = $urandom % 4;
      e = s <= 5 && v < 2 && (8 << s) * (v + 1) <= `FIFO_BYTES;
      apb(1, 8'h28, s << 4 | v << 2 | 2);
      rd(8'h28, s << 4 | v << 2 | 2);
      rd(8'h2c, e << 7);
      chk({buffer_size_code[1], bank_count_code[1], config_valid[1]}, s << 3 | v << 1 | e);
    end
    chk(memory_claim[1], 1);
    apb(1, 8'h28, 0);
    @(negedge pclk);
    chk(memory_claim[1], 0);
    apb(1, 8'h20, 8'h21);
    apb(1, 8'h20, 8'h01);
    @(negedge pclk);
    chk({stall_request[1], endpoint_on[1]}, 3);
    @(posedge pclk);
    setup_seen <= 2;
    @(posedge pclk);
    setup_seen <= 0;
    @(negedge pclk);
    chk(stall_request[1], 0);
    apb(1, 8'h20, 8'h19);
    @(negedge pclk);
    chk({stall_cancel[1], toggle_reset[1]}, 3);
    rd(8'h20, 1);
    apb(1, 8'h24, 8'h40);
    v = $urandom % 2;
    e = $urandom % 3;
    @(posedge pclk);
    {iso_overrun_seen, iso_starve_seen} <= {7'h2, 7'h2};
    toggle_state[1] <= 2'(v);
    busy_bank_count[1] <= 2'(e);
    @(posedge pclk);
    {iso_overrun_seen, iso_starve_seen} <= 0;
    apb(1, 8'h2c, 8'hff);
    chk(endpoint_irq_summary, 2);
    rd(8'h2c, 8'h60 | v << 2 | e);
    apb(1, 8'h2c, 0);
    rd(8'h2c, v << 2 | e);
    chk(endpoint_irq_summary, 0);
    apb(0, 8'h30, 0);
    chk(perr, 1);
    chk(r, 0);
    $display("test endpoint done");
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end
endmodule

// ==== testbench/usb_dev_ctrl_props.sv ====
/* checker for the usb device control registers, bound to usb_dev_ctrl.
   assumes: usb_dev_pkg compiled first, usb_dev_cfg.svh on the path. */
`timescale 1ns/100ps
`include "usb_dev_cfg.svh"
module usb_dev_ctrl_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // engine side
  input wire logic address_applied,
  input wire logic [`NUM_EP-1:0] setup_seen,
  input wire logic [`NUM_EP-1:0] iso_overrun_seen,
  input wire logic usb_irq,
  input wire logic [6:0] device_address,
  input wire logic address_activate,
  input wire logic [`NUM_EP-1:0] endpoint_fifo_reset_bits,
  input wire logic [`NUM_EP-1:0] stall_request,
  input wire logic [`NUM_EP-1:0] stall_cancel,
  input wire logic [`NUM_EP-1:0] toggle_reset,
  input wire usb_dev_pkg::xfer_kind_type [`NUM_EP-1:0] transfer_type,
  input wire logic [`NUM_EP-1:0] endpoint_irq_summary
);
  import usb_dev_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  a_stall_setup: assert property (|setup_seen && !wr |=> (stall_request & $past(setup_seen)) == 0)
    else $error("stall request kept after setup");
  a_cancel_pulse: assert property (|stall_cancel |-> $past(wr && paddr == 8'h20) ##1 stall_cancel == 0)
    else $error("stall cancel not a one cycle pulse");
  a_toggle_pulse: assert property (|toggle_reset |-> $past(wr && paddr == 8'h20) ##1 toggle_reset == 0)
    else $error("toggle reset not a one cycle pulse");
  a_addr_apply: assert property (address_applied && !wr |=> !address_activate)
    else $error("address activate not cleared");
  a_addr_load: assert property (wr && paddr == 8'h08 |=> device_address == $past(pwdata[6:0]))
    else $error("device address not loaded");
  a_fifo_load: assert property (wr && paddr == 8'h1c |=> endpoint_fifo_reset_bits == $past(pwdata[6:0]))
    else $error("fifo reset bits not loaded");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h2c |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_iso_summary: assert property (iso_overrun_seen[1] && transfer_type[1] == xfer_iso |=> endpoint_irq_summary[1])
    else $error("iso overrun not flagged");
  a_irq_hold: assert property (usb_irq && !wr |=> usb_irq)
    else $error("interrupt dropped without a write");
endmodule

bind usb_dev_ctrl usb_dev_ctrl_props usb_dev_ctrl_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .address_applied(address_applied),
  .setup_seen(setup_seen), .iso_overrun_seen(iso_overrun_seen), .usb_irq(usb_irq),
  .device_address(device_address), .address_activate(address_activate),
  .endpoint_fifo_reset_bits(endpoint_fifo_reset_bits), .stall_request(stall_request),
  .stall_cancel(stall_cancel), .toggle_reset(toggle_reset), .transfer_type(transfer_type),
  .endpoint_irq_summary(endpoint_irq_summary));

// ==== testbench/usb_host_model.sv ====
/* host side of the usb link: frame tokens and idle line.
   assumes: driven from the bench through its tasks. */
`timescale 1ns/100ps
module usb_host_model (
  // clock
  input wire logic pclk,
  // link events
  output logic sof_seen,
  output logic sof_crc_bad,
  output logic [10:0] sof_frame_number,
  output logic line_idle_j
);
  initial begin
    {sof_seen, sof_crc_bad, sof_frame_number, line_idle_j} = 0;
  end
  // one token per frame; qualifiers scrambled once released
  task automatic sof(input logic [10:0] n, input logic bad);
    @(posedge pclk);
    sof_seen <= 1;
    sof_crc_bad <= bad;
    sof_frame_number <= n;
    @(posedge pclk);
    sof_seen <= 0;
    sof_crc_bad <= ~bad;
    sof_frame_number <= ~n;
  endtask
  task automatic idle(input int cyc);
    @(posedge pclk);
    line_idle_j <= 1;
    repeat (cyc) @(posedge pclk);
    line_idle_j <= 0;
  endtask
endmodule
